// *** core/rtm_pkg.sv ***
// Shared constants and types for the tone measurement and timer block.
// Assumes the device clock stands in for the crystal; every period is a fixed division of it.
package rtm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Reference crystal and measurement window
	localparam int REF_XTAL_KHZ = 4032;
	localparam int CNT_CLK_HZ = 56000;
	localparam int CNT_DIV = REF_XTAL_KHZ * 1000 / CNT_CLK_HZ;
	localparam int WINDOW_US = 9125;
	localparam int WIN_TICKS = WINDOW_US * CNT_CLK_HZ / 1000000;
	localparam int LATE_PERCENT = 75;
	localparam int WIN_LATE_TICKS = WIN_TICKS * LATE_PERCENT / 100 + 1;

	////////////////////////////////////////////////////////////////////////////
	// Period timers
	localparam int TIMER_UNIT_MS = 10;
	localparam int TICK_DIV = REF_XTAL_KHZ * TIMER_UNIT_MS;
	localparam int NT_STEP_TICKS = 2;
	localparam int GPT_STEP_TICKS = 1;
	localparam logic [3:0] SETTING_RESET = 4'h0;

	////////////////////////////////////////////////////////////////////////////
	// Serial command bus
	localparam logic [7:0] CMD_GENERAL_RESET = 8'h01;
	localparam logic [7:0] CMD_READ_STATUS = 8'h30;
	localparam logic [7:0] CMD_READ_TONE = 8'h32;
	localparam logic [7:0] CMD_WRITE_NOTONE = 8'h33;
	localparam logic [7:0] CMD_WRITE_GPT = 8'h36;
	localparam int STAT_MEAS = 0;
	localparam int STAT_NOTONE = 1;
	localparam int STAT_GPT = 2;
	localparam logic [3:0] DEV_SYNC_IDLE = 4'h3;
	localparam logic [1:0] HOST_SYNC_IDLE = 2'h3;
	localparam int SCLK_HALF_CYC = 10;

	////////////////////////////////////////////////////////////////////////////
	// Controller register map
	localparam logic [7:0] HOST_ADR_CMD = 8'h00;
	localparam logic [7:0] HOST_ADR_STAT = 8'h04;
	localparam logic [7:0] HOST_ADR_REPLY = 8'h08;
	localparam int HOST_CMD_DATA_BIT = 16;
	localparam int HOST_CMD_RCNT_LSB = 17;

	typedef enum logic [1:0] {
		RTM_BAND_HIGH = 2'h0,
		RTM_BAND_MID = 2'h1,
		RTM_BAND_EXT = 2'h2
	} rtm_band_t;

	typedef enum logic [1:0] {
		MS_WAIT = 2'b01,
		MS_RUN = 2'b10
	} rtm_meas_state_t;

	typedef enum logic [4:0] {
		HS_IDLE = 5'b00001,
		HS_LEAD = 5'b00010,
		HS_LOW = 5'b00100,
		HS_HIGH = 5'b01000,
		HS_END = 5'b10000
	} rtm_host_state_t;

	// Ticks of the timer unit for setting n, doubled in mid band
	function automatic logic [5:0] rtm_ticks(input logic [3:0] n, input logic mid, input int step);
		int t;
		t = int'(n) * step * (mid ? 2 : 1);
		return t[5:0];
	endfunction

endpackage

// *** core/rtm_cbus_if.sv ***
// Serial command bus between the controller and the tone device.
// Reply line is pulled high while the device does not drive it.
`timescale 1ns/1ns
interface rtm_cbus_if;
	logic csn;
	logic sclk;
	logic cdata;
	logic rdata_drv;
	logic rdata_oe;
	logic rdata;
	logic irq_n;

	assign rdata = rdata_oe ? rdata_drv : 1'b1;

	modport dev (
		input csn,
		input sclk,
		input cdata,
		output rdata_drv,
		output rdata_oe,
		output irq_n
	);

	modport host (
		output csn,
		output sclk,
		output cdata,
		input rdata,
		input irq_n
	);
endinterface

// *** core/rtm_device.sv ***
// Tone measurement, no-tone timer and period timer behind the serial command bus.
// Assumes band and interrupt enables come from control logic on the same clock.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ns
module rtm_device #(
	parameter int CNT_DIV = rtm_pkg::CNT_DIV,
	parameter int TICK_DIV = rtm_pkg::TICK_DIV
) (
	input wire logic clk_i,
	input wire logic rst_i,
	rtm_cbus_if.dev bus,
	input wire logic tone_i,
	input wire logic signal_usable_i,
	input wire rtm_pkg::rtm_band_t band_i,
	input wire logic irq_en_tone_i,
	input wire logic irq_en_gpt_i,
	output logic [2:0] status_o,
	output logic [7:0] cycle_count_o,
	output logic [7:0] remainder_o
);
	import rtm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: sclk, csn, cdata, tone
	logic [3:0] s1_reg, s2_reg, s3_reg, flt_reg;
	logic [3:0] stable, rise, fall;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg <= DEV_SYNC_IDLE;
			s2_reg <= DEV_SYNC_IDLE;
			s3_reg <= DEV_SYNC_IDLE;
			flt_reg <= DEV_SYNC_IDLE;
		end else begin
			s1_reg <= {tone_i, bus.cdata, bus.csn, bus.sclk};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			flt_reg <= (s3_reg & stable) | (flt_reg & ~stable);
		end
	end

	assign stable = ~(s2_reg ^ s3_reg);
	assign rise = stable & s3_reg & ~flt_reg;
	assign fall = stable & ~s3_reg & flt_reg;

	////////////////////////////////////////////////////////////////////////////
	// Command receiver
	logic [7:0] rx_sh_reg, cmd_reg, byte_val;
	logic [2:0] bit_cnt_reg;
	logic first_reg;
	logic sclk_rise, sclk_fall, byte_done, cmd_ev, data_ev;
	logic gen_reset, stat_rd, tone_rd, nt_wr, gpt_wr;

	assign sclk_rise = rise[0] & ~flt_reg[1];
	assign sclk_fall = fall[0] & ~flt_reg[1];
	assign byte_val = {rx_sh_reg[6:0], flt_reg[2]};
	assign byte_done = sclk_rise && bit_cnt_reg == 3'h7;
	assign cmd_ev = byte_done && first_reg;
	assign data_ev = byte_done && !first_reg;
	assign gen_reset = cmd_ev && byte_val == CMD_GENERAL_RESET;
	assign stat_rd = cmd_ev && byte_val == CMD_READ_STATUS;
	assign tone_rd = cmd_ev && byte_val == CMD_READ_TONE;
	assign nt_wr = data_ev && cmd_reg == CMD_WRITE_NOTONE;
	assign gpt_wr = data_ev && cmd_reg == CMD_WRITE_GPT;

	always_ff @(posedge clk_i) begin
		if (rst_i || fall[1]) begin
			rx_sh_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			first_reg <= 1'b1;
			cmd_reg <= 8'h00;
		end else if (sclk_rise) begin
			rx_sh_reg <= byte_val;
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			if (byte_done) begin
				first_reg <= 1'b0;
				if (first_reg) begin
					cmd_reg <= byte_val;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reply shifter, next bit presented on each falling sclk
	logic [15:0] rep_sh_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rep_sh_reg <= 16'h0000;
			bus.rdata_drv <= 1'b1;
			bus.rdata_oe <= 1'b0;
		end else if (rise[1]) begin
			bus.rdata_oe <= 1'b0;
			bus.rdata_drv <= 1'b1;
		end else if (stat_rd) begin
			rep_sh_reg <= {5'h00, status_o, 8'h00};
			bus.rdata_oe <= 1'b1;
		end else if (tone_rd) begin
			rep_sh_reg <= {cycle_count_o, remainder_o};
			bus.rdata_oe <= 1'b1;
		end else if (sclk_fall && bus.rdata_oe) begin
			bus.rdata_drv <= rep_sh_reg[15];
			rep_sh_reg <= {rep_sh_reg[14:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frequency measurement
	rtm_meas_state_t state_reg;
	logic [7:0] win_ph_reg, rem_ph_reg, n_reg, div;
	logic [8:0] win_tk_reg, rem_tk_reg, rem_round;
	logic mid, run, tone_ev, win_wrap, rem_wrap, win_end, meas_abort, meas_ok, meas_late;

	assign mid = band_i == RTM_BAND_MID;
	assign div = mid ? 8'(2 * CNT_DIV) : 8'(CNT_DIV);
	// Full cycles in extended band, half-cycles otherwise
	assign tone_ev = (band_i == RTM_BAND_EXT) ? rise[3] : (rise[3] | fall[3]);
	assign run = state_reg == MS_RUN;
	assign win_wrap = win_ph_reg == div - 8'h01;
	assign rem_wrap = rem_ph_reg == div - 8'h01;
	assign win_end = run && win_wrap && win_tk_reg == 9'(WIN_TICKS - 1);
	assign meas_abort = run && (!signal_usable_i || (tone_ev && n_reg == 8'hff));
	// Closing clock of the window counts too
	assign rem_round = rem_tk_reg + {8'h00, (rem_ph_reg + 8'h01) >= (div >> 1)};
	assign meas_ok = win_end && !meas_abort && n_reg != 8'h00 && !rem_round[8];
	assign meas_late = run && win_tk_reg >= 9'(WIN_LATE_TICKS);

	always_ff @(posedge clk_i) begin
		if (rst_i || gen_reset) begin
			state_reg <= MS_WAIT;
			win_ph_reg <= 8'h00;
			win_tk_reg <= 9'h000;
			rem_ph_reg <= 8'h00;
			rem_tk_reg <= 9'h000;
			n_reg <= 8'h00;
		end else begin
			case (state_reg)
				MS_WAIT: begin
					if (tone_ev && signal_usable_i) begin
						state_reg <= MS_RUN;
						win_ph_reg <= 8'h00;
						win_tk_reg <= 9'h000;
						rem_ph_reg <= 8'h00;
						rem_tk_reg <= 9'h000;
						n_reg <= 8'h00;
					end
				end
				MS_RUN: begin
					if (meas_abort || win_end) begin
						state_reg <= MS_WAIT;
					end else begin
						win_ph_reg <= win_wrap ? 8'h00 : win_ph_reg + 8'h01;
						win_tk_reg <= win_tk_reg + {8'h00, win_wrap};
						if (tone_ev) begin
							n_reg <= n_reg + 8'h01;
							rem_ph_reg <= 8'h00;
							rem_tk_reg <= 9'h000;
						end else begin
							rem_ph_reg <= rem_wrap ? 8'h00 : rem_ph_reg + 8'h01;
							rem_tk_reg <= rem_tk_reg + {8'h00, rem_wrap};
						end
					end
				end
				default: state_reg <= MS_WAIT;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || gen_reset) begin
			cycle_count_o <= 8'h00;
			remainder_o <= 8'h00;
		end else if (meas_ok) begin
			cycle_count_o <= n_reg;
			remainder_o <= rem_round[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// No-tone one-shot
	logic [3:0] nt_set_reg;
	logic [15:0] nt_sub_reg;
	logic [5:0] nt_tk_reg;
	logic nt_run_reg, nt_pend_reg, nt_tick, nt_expire, nt_flag;

	assign nt_tick = nt_sub_reg == 16'(TICK_DIV - 1);
	assign nt_expire = nt_run_reg && nt_tick && nt_tk_reg == 6'h01 && !meas_ok;
	// Fade aborts the measurement but never stops the countdown
	assign nt_flag = (nt_expire && (!meas_late || meas_abort)) ||
		(nt_pend_reg && meas_abort);

	always_ff @(posedge clk_i) begin
		if (rst_i || gen_reset) begin
			nt_set_reg <= SETTING_RESET;
			nt_run_reg <= 1'b0;
			nt_sub_reg <= 16'h0000;
			nt_tk_reg <= 6'h00;
		end else begin
			if (nt_wr) begin
				nt_set_reg <= byte_val[3:0];
			end
			if (meas_ok) begin
				nt_run_reg <= nt_set_reg != 4'h0;
				nt_sub_reg <= 16'h0000;
				nt_tk_reg <= rtm_ticks(nt_set_reg, mid, NT_STEP_TICKS);
			end else if (nt_run_reg) begin
				nt_sub_reg <= nt_tick ? 16'h0000 : nt_sub_reg + 16'h0001;
				if (nt_tick) begin
					nt_tk_reg <= nt_tk_reg - 6'h01;
					if (nt_tk_reg == 6'h01) begin
						nt_run_reg <= 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || gen_reset || meas_ok || meas_abort) begin
			nt_pend_reg <= 1'b0;
		end else if (nt_expire && meas_late) begin
			nt_pend_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// General purpose period timer, self-repeating
	logic [3:0] gpt_set_reg;
	logic [15:0] gpt_sub_reg;
	logic [5:0] gpt_tk_reg;
	logic gpt_run_reg, gpt_tick, gpt_expire;

	assign gpt_tick = gpt_sub_reg == 16'(TICK_DIV - 1);
	assign gpt_expire = gpt_run_reg && gpt_tick && gpt_tk_reg == 6'h01 && !gpt_wr;

	always_ff @(posedge clk_i) begin
		if (rst_i || gen_reset) begin
			gpt_set_reg <= SETTING_RESET;
			gpt_run_reg <= 1'b0;
			gpt_sub_reg <= 16'h0000;
			gpt_tk_reg <= 6'h00;
		end else if (gpt_wr) begin
			gpt_set_reg <= byte_val[3:0];
			gpt_run_reg <= byte_val[3:0] != 4'h0;
			gpt_sub_reg <= 16'h0000;
			gpt_tk_reg <= rtm_ticks(byte_val[3:0], mid, GPT_STEP_TICKS);
		end else if (gpt_run_reg) begin
			gpt_sub_reg <= gpt_tick ? 16'h0000 : gpt_sub_reg + 16'h0001;
			if (gpt_tick) begin
				gpt_tk_reg <= (gpt_tk_reg == 6'h01) ?
					rtm_ticks(gpt_set_reg, mid, GPT_STEP_TICKS) : gpt_tk_reg - 6'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status flags and interrupt; a set in the clearing cycle wins
	logic [2:0] stat_set, stat_clr, stat_next, irq_en;

	always_comb begin
		stat_set = 3'h0;
		stat_set[STAT_MEAS] = meas_ok;
		stat_set[STAT_NOTONE] = nt_flag;
		stat_set[STAT_GPT] = gpt_expire;
		stat_clr = 3'h0;
		stat_clr[STAT_NOTONE] = nt_wr;
		stat_clr[STAT_GPT] = gpt_wr;
		if (stat_rd) begin
			stat_clr = 3'h7;
		end
		irq_en = {irq_en_gpt_i, irq_en_tone_i, irq_en_tone_i};
		stat_next = (status_o & ~stat_clr) | stat_set;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || gen_reset) begin
			status_o <= 3'h0;
			bus.irq_n <= 1'b1;
		end else begin
			status_o <= stat_next;
			bus.irq_n <= ~|(stat_next & irq_en);
		end
	end

endmodule

// *** core/rtm_host.sv ***
// Controller end: Wishbone classic slave registers driving the serial command bus.
// Assumes the device samples on rising sclk and presents reply bits after falling sclk.
`timescale 1ns/1ns
module rtm_host #(
	parameter int SCLK_HALF = rtm_pkg::SCLK_HALF_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	rtm_cbus_if.host bus,
	output logic irq_o
);
	import rtm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Reply and interrupt synchronisers
	logic [1:0] s1_reg, s2_reg, s3_reg, flt_reg, stable;

	assign stable = ~(s2_reg ^ s3_reg);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg <= HOST_SYNC_IDLE;
			s2_reg <= HOST_SYNC_IDLE;
			s3_reg <= HOST_SYNC_IDLE;
			flt_reg <= HOST_SYNC_IDLE;
			irq_o <= 1'b0;
		end else begin
			s1_reg <= {bus.irq_n, bus.rdata};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			flt_reg <= (s3_reg & stable) | (flt_reg & ~stable);
			irq_o <= ~flt_reg[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus slave
	rtm_host_state_t state_reg;
	logic [15:0] out_sh_reg, reply_reg;
	logic [5:0] bits_reg, rep_bits_reg;
	logic [7:0] hc_reg;
	logic req, cmd_wr, half_end, busy;
	logic [1:0] rcnt;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign busy = state_reg != HS_IDLE;
	assign cmd_wr = req && wb_we_i && wb_adr_i == HOST_ADR_CMD && &wb_sel_i[2:0] && !busy;
	assign rcnt = wb_dat_i[HOST_CMD_RCNT_LSB +: 2];
	assign half_end = hc_reg == 8'(SCLK_HALF - 1);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			if (req && !wb_we_i) begin
				case (wb_adr_i)
					HOST_ADR_STAT: wb_dat_o <= {30'h00000000, irq_o, busy};
					HOST_ADR_REPLY: wb_dat_o <= {16'h0000, reply_reg};
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial sequencer, sclk idles high
	always_ff @(posedge clk_i) begin
		if (rst_i || state_reg == HS_IDLE || half_end) begin
			hc_reg <= 8'h00;
		end else begin
			hc_reg <= hc_reg + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= HS_IDLE;
			bus.csn <= 1'b1;
			bus.sclk <= 1'b1;
			bus.cdata <= 1'b0;
			out_sh_reg <= 16'h0000;
			reply_reg <= 16'h0000;
			bits_reg <= 6'h00;
			rep_bits_reg <= 6'h00;
		end else begin
			case (state_reg)
				HS_IDLE: begin
					if (cmd_wr) begin
						// Address byte first, then optional data byte
						out_sh_reg <= wb_dat_i[15:0] << 8 | {8'h00, wb_dat_i[15:8]};
						rep_bits_reg <= {1'b0, rcnt, 3'h0};
						bits_reg <= 6'h08 + {2'b00, wb_dat_i[HOST_CMD_DATA_BIT], 3'h0} +
							{1'b0, rcnt, 3'h0};
						reply_reg <= 16'h0000;
						bus.csn <= 1'b0;
						state_reg <= HS_LEAD;
					end
				end
				HS_LEAD, HS_HIGH: begin
					if (half_end) begin
						if (state_reg == HS_HIGH && bits_reg == 6'h01) begin
							bus.csn <= 1'b1;
							state_reg <= HS_END;
						end else begin
							bus.sclk <= 1'b0;
							bus.cdata <= out_sh_reg[15];
							out_sh_reg <= {out_sh_reg[14:0], 1'b0};
							state_reg <= HS_LOW;
						end
						if (state_reg == HS_HIGH) begin
							bits_reg <= bits_reg - 6'h01;
						end
					end
				end
				HS_LOW: begin
					if (half_end) begin
						bus.sclk <= 1'b1;
						if (bits_reg <= rep_bits_reg) begin
							reply_reg <= {reply_reg[14:0], flt_reg[0]};
						end
						state_reg <= HS_HIGH;
					end
				end
				HS_END: begin
					if (half_end) begin
						state_reg <= HS_IDLE;
					end
				end
				default: state_reg <= HS_IDLE;
			endcase
		end
	end

endmodule

// *** tb/rtm_cbus_checker.sv ***
// Assertions on the serial command bus between controller and device.
// Takes the interface signals as plain inputs; both ends share clk_i.
`timescale 1ns/1ns
module rtm_cbus_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic csn,
	input wire logic sclk,
	input wire logic cdata,
	input wire logic rdata_drv,
	input wire logic rdata_oe,
	input wire logic irq_n
);
	logic sclk_q_reg;
	logic [5:0] bits_reg;
	////////////////////////////////////////////////////////////////////////////
	// Rising serial clocks seen in the current frame
	always_ff @(posedge clk_i) begin
		sclk_q_reg <= sclk;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || csn) begin
			bits_reg <= 6'h0;
		end else if (sclk && !sclk_q_reg) begin
			bits_reg <= bits_reg + 6'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_sclk_idle_high: assert property (csn |-> sclk)
		else $error("serial clock low outside a frame");
	a_select_lead: assert property ($fell(csn) |-> sclk [*8] ##[1:4] !sclk)
		else $error("select lead time wrong");
	a_low_phase: assert property ($fell(sclk) |-> !sclk [*8] ##[1:4] sclk)
		else $error("serial clock low phase wrong");
	a_high_phase: assert property ($rose(sclk) |-> sclk [*8])
		else $error("serial clock high phase short");
	a_cmd_bit_stable: assert property (!csn && $past(!csn) && sclk && $past(sclk) |->
		$stable(cdata))
		else $error("command bit moved while clock high");
	a_whole_bytes: assert property ($rose(csn) |-> bits_reg[2:0] == 3'h0 && bits_reg != 6'h0)
		else $error("frame not whole bytes");
	a_select_gap: assert property ($rose(csn) |-> csn [*8])
		else $error("select gap short");
	a_reply_released: assert property (csn [*8] |-> !rdata_oe)
		else $error("reply driven while deselected");
	a_reply_stable: assert property (!csn && sclk && $past(sclk) && rdata_oe && $past(rdata_oe)
		|-> $stable(rdata_drv))
		else $error("reply bit moved while clock high");
	a_irq_clear_frame: assert property ($rose(irq_n) |-> !csn || $past(!csn))
		else $error("interrupt cleared outside a command");
	c_irq: cover property ($fell(irq_n));
	c_reply: cover property (rdata_oe && !csn);
	c_long_frame: cover property ($rose(csn) && bits_reg == 6'h18);
endmodule

// *** tb/rx_tone_measure_notone_timer_tb.sv ***
// Bench: Wishbone master on the controller, tone source and mode inputs on the device.
// Shortened dividers; expectations derive from CDIV and TDIV.
`timescale 1ns/1ns
module rx_tone_measure_notone_timer_tb;
	import rtm_pkg::*;
	localparam int CDIV = 4;
	localparam int TDIV = 200;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic wb_cyc = 1'h0;
	logic wb_stb = 1'h0;
	logic wb_we = 1'h0;
	logic [7:0] wb_adr = 8'h0;
	logic [31:0] wb_dw = 32'h0;
	logic [31:0] wb_dr;
	logic wb_ack;
	logic irq_o;
	logic tone_i = 1'h0;
	logic usable = 1'h0;
	rtm_band_t band = RTM_BAND_HIGH;
	logic en_tone = 1'h0;
	logic en_gpt = 1'h0;
	logic [2:0] status;
	logic [7:0] cnt;
	logic [7:0] rem;
	logic tone_run = 1'h0;
	int half_p = 16;
	int tcnt = 0;
	int cyc_n = 0;
	int fails = 0;
	int checks = 0;
	int exp_q[$];
	rtm_cbus_if cbus();
	rtm_host u_rtm_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dw),
		.wb_dat_o(wb_dr), .wb_ack_o(wb_ack), .bus(cbus), .irq_o(irq_o));
	rtm_device #(.CNT_DIV(CDIV), .TICK_DIV(TDIV)) u_rtm_device (.clk_i(clk_i), .rst_i(rst_i),
		.bus(cbus), .tone_i(tone_i), .signal_usable_i(usable), .band_i(band),
		.irq_en_tone_i(en_tone), .irq_en_gpt_i(en_gpt), .status_o(status),
		.cycle_count_o(cnt), .remainder_o(rem));
	rtm_cbus_checker u_rtm_cbus_checker (.clk_i(clk_i), .rst_i(rst_i), .csn(cbus.csn),
		.sclk(cbus.sclk), .cdata(cbus.cdata), .rdata_drv(cbus.rdata_drv),
		.rdata_oe(cbus.rdata_oe), .irq_n(cbus.irq_n));
	////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	// Square tone, half period in clocks
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 100000) begin
			fails++;
			conclude();
		end
		if (tone_run && tcnt >= half_p - 1) begin
			tcnt <= 0;
			tone_i <= !tone_i;
		end else if (tone_run) begin
			tcnt <= tcnt + 1;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] rd);
		wb_cyc <= 1'h1;
		wb_stb <= 1'h1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dw <= dat;
		do @(posedge clk_i); while (wb_ack !== 1'h1);
		rd = wb_dr;
		wb_cyc <= 1'h0;
		wb_stb <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic cmd(input logic [7:0] a, input logic [7:0] d, input logic snd,
		input logic [1:0] rc, output logic [15:0] rep);
		logic [31:0] rd;
		wb(1'h1, HOST_ADR_CMD, {13'h0, rc, snd, d, a}, rd);
		do wb(1'h0, HOST_ADR_STAT, 32'h0, rd); while (rd[0] !== 1'h0);
		wb(1'h0, HOST_ADR_REPLY, 32'h0, rd);
		rep = rd[15:0];
	endtask
	task automatic wait_st(input int b, output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (status[b] !== 1'h1 && n < 20000);
		if (status[b] !== 1'h1) begin
			fails++;
			conclude();
		end
	endtask
	// Whole cycles truncated, remainder rounded to counting ticks
	function automatic void model(input rtm_band_t b, input int p);
		int w, cd, q, rm;
		cd = (b == RTM_BAND_MID) ? 2 * CDIV : CDIV;
		q = (b == RTM_BAND_EXT) ? 2 * p : p;
		w = 511 * cd;
		rm = w - (w / q) * q;
		exp_q.push_back(w / q);
		exp_q.push_back((2 * rm + cd) / (2 * cd));
	endfunction
	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [15:0] rep;
		logic [31:0] rd;
		int n, g, p, en, er, k;
		rtm_band_t b;
		n = $urandom(41855);
		repeat (16) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (6) @(posedge clk_i);
		chk("status", 16'(status), 16'h0);
		chk("irq", 16'(irq_o), 16'h0);
		wb(1'h0, 8'hfc, 32'h0, rd);
		chk("unmapped", rd[15:0], 16'h0);
		cmd(CMD_WRITE_NOTONE, 8'h01, 1'h1, 2'h0, rep);
		repeat (1000) @(posedge clk_i);
		chk("notone_idle", 16'(status[1]), 16'h0);
		cmd(CMD_GENERAL_RESET, 8'h0, 1'h0, 2'h0, rep);
		$display("test reset done");
		en_tone <= 1'h1;
		usable <= 1'h1;
		tone_run <= 1'h1;
		for (int i = 0; i < 3; i++) begin
			b = (i == 0) ? RTM_BAND_HIGH : ((i == 1) ? RTM_BAND_EXT : RTM_BAND_MID);
			p = (i == 2) ? 16 : 12 + 4 * ($urandom % 2);
			band <= b;
			half_p <= p;
			wait_st(0, n);
			cmd(CMD_READ_STATUS, 8'h0, 1'h0, 2'h1, rep);
			chk("stat_meas", 16'(rep[0]), 16'h1);
			chk("stat_clr", 16'(status), 16'h0);
			// Next result may straddle the band change
			wait_st(0, n);
			cmd(CMD_READ_STATUS, 8'h0, 1'h0, 2'h1, rep);
			wait_st(0, n);
			model(b, p);
			en = exp_q.pop_front();
			er = exp_q.pop_front();
			chk("count", 16'(cnt), 16'(en));
			chk("remainder", 16'(rem), 16'(er));
			repeat (6) @(posedge clk_i);
			chk("irq_meas", 16'(irq_o), 16'h1);
			cmd(CMD_READ_TONE, 8'h0, 1'h0, 2'h2, rep);
			chk("reply_tone", rep, {8'(en), 8'(er)});
			chk("notone_off", 16'(status[1]), 16'h0);
			$display("test band %0d done", i);
		end
		for (int v = 0; v < 2; v++) begin
			g = 1 + $urandom % 3;
			k = v + 1;
			band <= v ? RTM_BAND_MID : RTM_BAND_HIGH;
			half_p <= 16;
			tone_run <= 1'h1;
			usable <= 1'h1;
			cmd(CMD_WRITE_NOTONE, 8'(g), 1'h1, 2'h0, rep);
			cmd(CMD_READ_STATUS, 8'h0, 1'h0, 2'h1, rep);
			wait_st(0, n);
			if (v == 0) begin
				tone_run <= 1'h0;
			end else begin
				usable <= 1'h0;
			end
			wait_st(1, n);
			chk("notone_time", 16'(n >= 400 * g * k - 210 && n <= 400 * g * k + 10), 16'h1);
			repeat (6) @(posedge clk_i);
			chk("irq_notone", 16'(irq_o), 16'h1);
			if (v == 0) begin
				cmd(CMD_READ_STATUS, 8'h0, 1'h0, 2'h1, rep);
				chk("stat_notone", 16'(rep[1]), 16'h1);
				chk("irq_clr", 16'(irq_o), 16'h0);
			end else begin
				cmd(CMD_WRITE_NOTONE, 8'(g), 1'h1, 2'h0, rep);
			end
			chk("notone_clr", 16'(status[1]), 16'h0);
			$display("test notone %0d done", v);
		end
		band <= RTM_BAND_HIGH;
		usable <= 1'h1;
		tone_run <= 1'h1;
		cmd(CMD_WRITE_NOTONE, 8'h05, 1'h1, 2'h0, rep);
		wait_st(0, n);
		cmd(CMD_READ_STATUS, 8'h0, 1'h0, 2'h1, rep);
		// Countdown of 2000 clocks ends late in the following window
		wait_st(0, n);
		repeat (2010) @(posedge clk_i);
		chk("late_hold", 16'(status[1]), 16'h0);
		usable <= 1'h0;
		wait_st(1, n);
		chk("late_abort", 16'(n <= 20), 16'h1);
		$display("test late measurement done");
		tone_run <= 1'h0;
		cmd(CMD_READ_STATUS, 8'h0, 1'h0, 2'h1, rep);
		g = 1 + $urandom % 3;
		cmd(CMD_WRITE_GPT, 8'(g), 1'h1, 2'h0, rep);
		wait_st(2, n);
		chk("gpt_time", 16'(n >= 200 * g - 230 && n <= 200 * g + 5), 16'h1);
		repeat (6) @(posedge clk_i);
		chk("gpt_masked", 16'(irq_o), 16'h0);
		en_gpt <= 1'h1;
		cmd(CMD_READ_STATUS, 8'h0, 1'h0, 2'h1, rep);
		chk("stat_gpt", 16'(rep[2]), 16'h1);
		wait_st(2, n);
		chk("gpt_rerun", 16'(n <= 200 * g + 5), 16'h1);
		repeat (6) @(posedge clk_i);
		chk("irq_gpt", 16'(irq_o), 16'h1);
		cmd(CMD_WRITE_GPT, 8'h00, 1'h1, 2'h0, rep);
		chk("gpt_clr", 16'(status[2]), 16'h0);
		$display("test timer done");
		conclude();
	end
endmodule
